// ==== logic/esp_fifo.v ====
`timescale 1ns/1ps
`default_nettype none

module esp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk_sys,
    input  wire             arst_n,
    input  wire             flush,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);

    // depth must be 2**AW; pointers carry one wrap bit
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW:0]      wrPtr_reg;
    reg [AW:0]      rdPtr_reg;

    wire full  = (wrPtr_reg[AW] != rdPtr_reg[AW]) &&
                 (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
    wire empty = (wrPtr_reg == rdPtr_reg);
    wire push  = inValid & inReady;
    wire pop   = outValid & outReady;

    assign inReady  = ~full & ~flush;
    assign outValid = ~empty & ~flush;
    assign outData  = store[rdPtr_reg[AW-1:0]];

    always @(posedge clk_sys) begin
        if (push) begin
            store[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_reg <= {(AW+1){1'b0}};
            rdPtr_reg <= {(AW+1){1'b0}};
        end else if (flush) begin
            wrPtr_reg <= {(AW+1){1'b0}};
            rdPtr_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
        end
    end

endmodule // esp_fifo

`default_nettype wire

// ==== logic/esp_regs.vh ====
`ifndef ESP_REGS_VH
`define ESP_REGS_VH

// array geometry
`define ESP_MEM_DEPTH    16384
`define ESP_ADDR_W       14
`define ESP_ID_BYTES     64
`define ESP_ID_AW        6

// write staging buffer
`define ESP_FIFO_DEPTH   32
`define ESP_FIFO_AW      5
`define ESP_DATA_W       8

// internal write cycle length in clk_sys cycles
`define ESP_WRITE_CYC    16'h0040

// instruction codes
`define ESP_OP_WREN      8'h11
`define ESP_OP_WRDI      8'h12
`define ESP_OP_RDST      8'h13
`define ESP_OP_READ      8'h21
`define ESP_OP_WRITE     8'h22
`define ESP_OP_RDID      8'h31
`define ESP_OP_WRID      8'h32
`define ESP_OP_RDLK      8'h33
`define ESP_OP_LOCK      8'h34

// status byte bit positions and reset values
`define ESP_ST_WIP       0
`define ESP_ST_WEL       1
`define ESP_WEL_RST      1'b0
`define ESP_WIP_RST      1'b0
`define ESP_LOCK_RST     1'b0

`endif

// ==== logic/esp_slave_port.v ====
`timescale 1ns/1ps
`default_nettype none
`include "esp_regs.vh"

module esp_slave_port #(
    parameter        MEM_DEPTH    = `ESP_MEM_DEPTH,
    parameter        ADDR_W       = `ESP_ADDR_W,
    parameter        ID_BYTES     = `ESP_ID_BYTES,
    parameter        ID_AW        = `ESP_ID_AW,
    parameter        FIFO_DEPTH   = `ESP_FIFO_DEPTH,
    parameter        FIFO_AW      = `ESP_FIFO_AW,
    parameter [15:0] WRITE_CYCLES = `ESP_WRITE_CYC
) (
    input  wire clk_sys,
    input  wire arst_n,
    input  wire sck,
    input  wire csN,
    input  wire sdi,
    input  wire holdN,
    output wire sdo,
    output wire sdoOe,
    output wire activePower,
    output wire writeBusy
);

    localparam [5:0] ST_CMD  = 6'b000001;
    localparam [5:0] ST_AHI  = 6'b000010;
    localparam [5:0] ST_ALO  = 6'b000100;
    localparam [5:0] ST_RD   = 6'b001000;
    localparam [5:0] ST_WR   = 6'b010000;
    localparam [5:0] ST_SKIP = 6'b100000;

    // pins from the master are asynchronous to clk_sys
    wire [3:0] pinIn = {sck, csN, sdi, holdN};
    reg  [3:0] pinMeta_reg;
    reg  [3:0] pinSync_reg;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            // csN stages reset low so reset itself never passes for a high level
            pinMeta_reg <= 4'hB;
            pinSync_reg <= 4'hB;
        end else begin
            pinMeta_reg <= pinIn;
            pinSync_reg <= pinMeta_reg;
        end
    end

    wire sckS  = pinSync_reg[3];
    wire csS   = pinSync_reg[2];
    wire sdiS  = pinSync_reg[1];
    wire holdS = pinSync_reg[0];

    reg [7:0]  memArr [0:MEM_DEPTH-1];
    reg [7:0]  idArr  [0:ID_BYTES-1];

    reg        seenHigh_reg;
    reg        selPrev_reg;
    reg        sckPrev_reg;
    reg        holdAct_reg;
    reg [5:0]  state_reg;
    reg [7:0]  op_reg;
    reg [2:0]  bitCnt_reg;
    reg [6:0]  rxShift_reg;
    reg [7:0]  addrHi_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [7:0]  txShift_reg;
    reg        sdo_reg;
    reg        txOn_reg;
    reg        gotData_reg;
    reg        wel_reg;
    reg        wip_reg;
    reg        locked_reg;
    reg        lockPend_reg;
    reg        wcId_reg;
    reg [ADDR_W-1:0] wcAddr_reg;
    reg [15:0] wcCnt_reg;
    reg        active_reg;
    reg [7:0]  txSrc;

    // select only after a high level has been seen since reset
    wire selected = seenHigh_reg & ~csS;
    wire deselEvt = selPrev_reg & ~selected;
    wire live     = selected & ~holdAct_reg;
    wire sckRise  = live & sckS & ~sckPrev_reg;
    wire sckFall  = live & ~sckS & sckPrev_reg;
    wire [7:0] rxByte  = {rxShift_reg, sdiS};
    wire byteDone = sckRise & (bitCnt_reg == 3'h7);
    wire cmdByte  = byteDone & (state_reg == ST_CMD);
    wire [15:0] addrFull = {addrHi_reg, rxByte};
    wire [ADDR_W-1:0] rdAddr = (state_reg == ST_ALO) ? addrFull[ADDR_W-1:0] : addr_reg;
    wire [7:0] opNow = (state_reg == ST_CMD) ? rxByte : op_reg;

    wire welSet = cmdByte & (rxByte == `ESP_OP_WREN) & ~wip_reg;
    wire welClr = cmdByte & (rxByte == `ESP_OP_WRDI) & ~wip_reg;

    wire opIsMem  = (op_reg == `ESP_OP_WRITE);
    wire opIsId   = (op_reg == `ESP_OP_WRID);
    wire opIsLock = (op_reg == `ESP_OP_LOCK);

    // a write commits only on a clean deselect after whole bytes
    wire commitGo = deselEvt & ~holdAct_reg & (state_reg == ST_WR) &
                    (bitCnt_reg == 3'h0) & gotData_reg & wel_reg &
                    (opIsMem | ((opIsId | opIsLock) & ~locked_reg));
    wire fifoFlush = deselEvt & ~commitGo;

    wire       fifoInReady;
    wire       fifoOutValid;
    wire [7:0] fifoOutData;
    wire       fifoPush = byteDone & (state_reg == ST_WR) & ~opIsLock;
    wire       wcEnd    = wip_reg & (wcCnt_reg == 16'h0000) & ~fifoOutValid;

    esp_fifo #(
        .WIDTH (`ESP_DATA_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .flush    (fifoFlush),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .inData   (rxByte),
        .outValid (fifoOutValid),
        .outReady (wip_reg),
        .outData  (fifoOutData)
    );

    // next byte to return, chosen by the running instruction
    always @* begin
        txSrc = 8'h00;
        case (opNow)
            `ESP_OP_RDST: begin
                txSrc[`ESP_ST_WIP] = wip_reg;
                txSrc[`ESP_ST_WEL] = wel_reg;
            end
            `ESP_OP_RDLK: txSrc[0] = locked_reg;
            `ESP_OP_READ: txSrc = memArr[rdAddr];
            `ESP_OP_RDID: txSrc = idArr[rdAddr[ID_AW-1:0]];
            default:      txSrc = 8'h00;
        endcase
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            seenHigh_reg <= 1'b0;
            selPrev_reg  <= 1'b0;
            sckPrev_reg  <= 1'b0;
            holdAct_reg  <= 1'b0;
            active_reg   <= 1'b0;
        end else begin
            if (csS) begin
                seenHigh_reg <= 1'b1;
            end
            selPrev_reg <= selected;
            sckPrev_reg <= sckS;
            // hold level only changes while the serial clock is low; deselect clears it at any level
            if (!selected) begin
                holdAct_reg <= 1'b0;
            end else if (!sckS) begin
                holdAct_reg <= ~holdS;
            end
            active_reg <= selected | wip_reg | commitGo;
        end
    end

    // frame sequencer
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= ST_CMD;
            op_reg      <= 8'h00;
            bitCnt_reg  <= 3'h0;
            rxShift_reg <= 7'h00;
            addrHi_reg  <= 8'h00;
            addr_reg    <= {ADDR_W{1'b0}};
            txShift_reg <= 8'h00;
            sdo_reg     <= 1'b0;
            txOn_reg    <= 1'b0;
            gotData_reg <= 1'b0;
        end else if (!selected) begin
            // deselect clears the interface, held or not
            state_reg   <= ST_CMD;
            bitCnt_reg  <= 3'h0;
            txOn_reg    <= 1'b0;
            gotData_reg <= 1'b0;
        end else if (sckRise) begin
            bitCnt_reg  <= bitCnt_reg + 3'h1;
            rxShift_reg <= rxByte[6:0];
            if (bitCnt_reg == 3'h7) begin
                case (state_reg)
                    ST_CMD: begin
                        op_reg <= rxByte;
                        // only status may be read while busy
                        if (rxByte == `ESP_OP_RDST ||
                            (rxByte == `ESP_OP_RDLK && !wip_reg)) begin
                            txShift_reg <= txSrc;
                            state_reg   <= ST_RD;
                        end else if (!wip_reg &&
                                     (rxByte == `ESP_OP_READ || rxByte == `ESP_OP_WRITE ||
                                      rxByte == `ESP_OP_RDID || rxByte == `ESP_OP_WRID ||
                                      rxByte == `ESP_OP_LOCK)) begin
                            state_reg <= ST_AHI;
                        end else begin
                            state_reg <= ST_SKIP;
                        end
                    end
                    ST_AHI: begin
                        addrHi_reg <= rxByte;
                        state_reg  <= ST_ALO;
                    end
                    ST_ALO: begin
                        addr_reg <= addrFull[ADDR_W-1:0];
                        if (op_reg == `ESP_OP_READ || op_reg == `ESP_OP_RDID) begin
                            txShift_reg <= txSrc;
                            addr_reg    <= addrFull[ADDR_W-1:0] + 1'b1;
                            state_reg   <= ST_RD;
                        end else begin
                            state_reg <= ST_WR;
                        end
                    end
                    ST_RD: begin
                        txShift_reg <= txSrc;
                        addr_reg    <= addr_reg + 1'b1;
                    end
                    ST_WR: begin
                        // bytes beyond the buffer are dropped
                        if (fifoInReady) begin
                            gotData_reg <= 1'b1;
                        end
                    end
                    ST_SKIP: state_reg <= ST_SKIP;
                    default: state_reg <= ST_SKIP;
                endcase
            end
        end else if (sckFall && state_reg == ST_RD) begin
            sdo_reg     <= txShift_reg[7];
            txShift_reg <= {txShift_reg[6:0], 1'b0};
            txOn_reg    <= 1'b1;
        end
    end

    // internal write cycle, runs on after deselect
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wel_reg      <= `ESP_WEL_RST;
            wip_reg      <= `ESP_WIP_RST;
            locked_reg   <= `ESP_LOCK_RST;
            lockPend_reg <= 1'b0;
            wcId_reg     <= 1'b0;
            wcAddr_reg   <= {ADDR_W{1'b0}};
            wcCnt_reg    <= 16'h0000;
        end else begin
            if (welSet) begin
                wel_reg <= 1'b1;
            end else if (welClr || wcEnd) begin
                wel_reg <= 1'b0;
            end
            if (commitGo) begin
                wip_reg      <= 1'b1;
                wcCnt_reg    <= WRITE_CYCLES;
                wcAddr_reg   <= addr_reg;
                wcId_reg     <= opIsId;
                lockPend_reg <= opIsLock;
            end else if (wip_reg) begin
                if (wcCnt_reg != 16'h0000) begin
                    wcCnt_reg <= wcCnt_reg - 16'h0001;
                end
                if (fifoOutValid) begin
                    // stay inside one page
                    wcAddr_reg[ID_AW-1:0] <= wcAddr_reg[ID_AW-1:0] + 1'b1;
                end
                if (wcEnd) begin
                    wip_reg      <= 1'b0;
                    lockPend_reg <= 1'b0;
                    if (lockPend_reg) begin
                        locked_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // arrays carry no reset, like the cells they model
    always @(posedge clk_sys) begin
        if (wip_reg && fifoOutValid) begin
            if (wcId_reg) begin
                idArr[wcAddr_reg[ID_AW-1:0]] <= fifoOutData;
            end else begin
                memArr[wcAddr_reg] <= fifoOutData;
            end
        end
    end

    assign sdo         = sdo_reg;
    assign sdoOe       = txOn_reg & live;
    assign activePower = active_reg;
    assign writeBusy   = wip_reg;

endmodule // esp_slave_port

`default_nettype wire

// ==== testbench/esp_slave_port_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module esp_slave_port_assertions #(
    parameter [15:0] WRITE_CYCLES = 16'h0040
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic sck,
    input wire logic csN,
    input wire logic sdi,
    input wire logic holdN,
    input wire logic sdo,
    input wire logic sdoOe,
    input wire logic activePower,
    input wire logic writeBusy
);
    logic        hiSeen_reg;
    logic [15:0] busyCnt_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hiSeen_reg  <= 1'b0;
            busyCnt_reg <= 16'h0000;
        end else begin
            hiSeen_reg  <= hiSeen_reg | csN;
            busyCnt_reg <= writeBusy ? busyCnt_reg + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence idle_s; csN [*4]; endsequence
    sequence sel_s; !csN [*5]; endsequence
    // hold only counts once the sync stages have seen it with sck low
    sequence held_s; (!csN && !holdN && !sck) [*5]; endsequence
    deselOff_a: assert property (csN [*5] |-> !sdoOe)
        else $error("sdo driven while deselected");
    holdFloat_a: assert property (held_s |-> !sdoOe)
        else $error("sdo driven during hold");
    holdKeep_a: assert property (held_s |-> activePower)
        else $error("hold dropped the selection");
    selActive_a: assert property (idle_s ##1 sel_s |-> activePower)
        else $error("selected but not active");
    standby_a: assert property ((csN && !writeBusy) [*6] |-> !activePower)
        else $error("no standby when idle and deselected");
    busyAct_a: assert property (writeBusy |-> activePower)
        else $error("standby during write cycle");
    busyMin_a: assert property ($fell(writeBusy) |-> busyCnt_reg >= WRITE_CYCLES - 16'h0001)
        else $error("write cycle too short");
    busyMax_a: assert property (writeBusy |-> busyCnt_reg <= WRITE_CYCLES + 16'h0040)
        else $error("write cycle too long");
    edgeOut_a: assert property ($changed(sdo) |-> !sck)
        else $error("sdo changed while sck high");
    preSel_a: assert property (!hiSeen_reg |-> !sdoOe && !writeBusy)
        else $error("acted before a select edge");
    oeRise_a: assert property ($rose(sdoOe) |-> !csN && !sck)
        else $error("sdo enabled outside a read phase");
endmodule // esp_slave_port_assertions
`default_nettype wire

// ==== testbench/esp_slave_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "esp_regs.vh"
module esp_slave_port_tb;
    localparam [15:0] WRITE_CYCLES = 16'h0190;
    logic       clk_sys;
    logic       arst_n;
    wire logic  sck;
    wire logic  csN;
    wire logic  sdi;
    wire logic  holdN;
    wire logic  sdo;
    wire logic  sdoOe;
    wire logic  activePower;
    wire logic  writeBusy;
    logic       sawOe = 1'b0;
    logic [7:0] rx;
    int         miscompares;
    int         tests_run;
    esp_slave_port #(.WRITE_CYCLES(WRITE_CYCLES)) esp_slave_port_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .sck(sck), .csN(csN), .sdi(sdi),
        .holdN(holdN), .sdo(sdo), .sdoOe(sdoOe), .activePower(activePower),
        .writeBusy(writeBusy));
    esp_spi_master esp_spi_master_inst (
        .clk_sys(clk_sys), .sdo(sdo), .sdoOe(sdoOe), .sck(sck), .csN(csN),
        .sdi(sdi), .holdN(holdN));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (sdoOe === 1'b1) sawOe <= 1'b1;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [39:0] tx, input int n);
        esp_spi_master_inst.frame(tx, n, -1, 1'b0, rx);
    endtask
    task automatic idle();
        int k;
        k = 0;
        while (writeBusy !== 1'b0 && k < 2000) begin
            @(posedge clk_sys);
            k++;
        end
        repeat (2) @(posedge clk_sys);
        chk({6'h00, writeBusy, activePower}, 8'h00);
    endtask
    task automatic t_preSel();
        send({`ESP_OP_READ, 32'h0}, 4);
        chk({7'h00, sawOe}, 8'h00);
    endtask
    // 0xFFFF must fold to the top byte; second byte wraps within the page
    task automatic t_write();
        send({`ESP_OP_WREN, 32'h0}, 1);
        send({`ESP_OP_WRITE, 16'hFFFF, 16'hA53C}, 5);
        chk({6'h00, writeBusy, activePower}, 8'h03);
        send({`ESP_OP_RDST, 32'h0}, 2);
        chk(rx, 8'h03);
        idle();
        send({`ESP_OP_RDST, 32'h0}, 2);
        chk(rx, 8'h00);
        send({`ESP_OP_READ, 16'hFFFF, 16'h0}, 4);
        chk(rx, 8'hA5);
        send({`ESP_OP_READ, 16'h3FC0, 16'h0}, 4);
        chk(rx, 8'h3C);
    endtask
    // a whole data byte is in before the hold, so only the hold can stop it
    task automatic t_hold();
        send({`ESP_OP_WREN, 32'h0}, 1);
        esp_spi_master_inst.frame({`ESP_OP_WRITE, 16'h3FC0, 16'h7700}, 4, 32, 1'b1, rx);
        chk({7'h00, writeBusy}, 8'h00);
        send({`ESP_OP_RDST, 32'h0}, 2);
        chk(rx, 8'h02);
        esp_spi_master_inst.frame({`ESP_OP_READ, 16'h3FC0, 16'h0}, 4, 28, 1'b0, rx);
        chk(rx, 8'h3C);
    endtask
    task automatic t_id();
        send({`ESP_OP_WREN, 32'h0}, 1);
        send({`ESP_OP_WRID, 16'h0000, 16'h5A00}, 4);
        idle();
        send({`ESP_OP_RDID, 32'h0}, 4);
        chk(rx, 8'h5A);
        send({`ESP_OP_WREN, 32'h0}, 1);
        send({`ESP_OP_LOCK, 32'h0}, 4);
        idle();
        send({`ESP_OP_WREN, 32'h0}, 1);
        send({`ESP_OP_WRID, 16'h0000, 16'hC300}, 4);
        idle();
        send({`ESP_OP_RDID, 32'h0}, 4);
        chk(rx, 8'h5A);
        send({`ESP_OP_RDLK, 32'h0}, 2);
        chk(rx, 8'h01);
        send({`ESP_OP_RDST, 32'h0}, 2);
        chk(rx, 8'h02);
        send({`ESP_OP_WRDI, 32'h0}, 1);
        send({`ESP_OP_RDST, 32'h0}, 2);
        chk(rx, 8'h00);
    endtask
    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        miscompares = 0;
        tests_run = 0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_preSel();
        t_write();
        t_hold();
        t_id();
        stop_test();
    end
    // whole run is near 5500 clocks; this leaves ample margin
    initial begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        stop_test();
    end
endmodule // esp_slave_port_tb
bind esp_slave_port esp_slave_port_assertions #(.WRITE_CYCLES(WRITE_CYCLES))
    esp_slave_port_assertions_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .sck(sck), .csN(csN), .sdi(sdi),
    .holdN(holdN), .sdo(sdo), .sdoOe(sdoOe), .activePower(activePower),
    .writeBusy(writeBusy));
`default_nettype wire

// ==== testbench/esp_spi_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module esp_spi_master (
    input  wire logic clk_sys,
    input  wire logic sdo,
    input  wire logic sdoOe,
    output var  logic sck,
    output var  logic csN,
    output var  logic sdi,
    output var  logic holdN
);
    logic      junk;
    wire logic line;
    // no pull on the data line: released, it toggles rather than hold a value
    assign line = sdoOe ? sdo : junk;
    initial begin
        sck   = 1'b0;
        csN   = 1'b0;
        sdi   = 1'b0;
        holdN = 1'b1;
        junk  = 1'b0;
    end
    always @(posedge clk_sys) junk <= ~junk;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // mode 0, 5 clocks low and 3 high per bit; hold before bit hAt
    task automatic frame(input logic [39:0] tx, input int n, input int hAt,
                         input bit drop, output logic [7:0] rx);
        rx = 8'h00;
        csN <= 1'b0;
        tick(4);
        for (int i = 0; i < n * 8 + (drop ? 1 : 0); i++) begin
            sck <= 1'b0;
            sdi <= tx[39 - i];
            if (i == hAt) begin
                tick(2);
                holdN <= 1'b0;
                tick(6);
                sck <= 1'b1;
                sdi <= ~tx[39 - i];
                tick(3);
                sck <= 1'b0;
                sdi <= tx[39 - i];
                tick(5);
                if (drop) begin
                    csN <= 1'b1;
                    tick(8);
                    holdN <= 1'b1;
                    tick(8);
                    return;
                end
                holdN <= 1'b1;
                tick(2);
            end
            tick(5);
            rx = {rx[6:0], line};
            sck <= 1'b1;
            tick(3);
        end
        sck <= 1'b0;
        tick(4);
        csN <= 1'b1;
        tick(8);
    endtask
endmodule // esp_spi_master
`default_nettype wire
